// File: rtl/itc_defines.svh
/*
 * Register offsets, field positions, reset values and tone constants
 * for the inband tone codec.
 * Assumes a 16-bit register port with byte-wide addresses.
 */
`ifndef ITC_DEFINES_SVH
`define ITC_DEFINES_SVH

// ============================================================
// register offsets
`define ITC_ADDR_MODE 8'hC1
`define ITC_ADDR_TXTONE 8'hC3
`define ITC_ADDR_IRQST 8'hC6
`define ITC_ADDR_PROG 8'hC8
`define ITC_ADDR_TONEST 8'hCC
`define ITC_ADDR_IRQEN 8'hCE
`define ITC_ADDR_PSEL 8'hD0

// ============================================================
// field positions
`define ITC_MODE_MSB 11
`define ITC_MODE_LSB 9
`define ITC_MODE_DTMF_BIT 8
`define ITC_IRQ_INBAND_BIT 13
`define ITC_IRQ_DTMF_BIT 12
`define ITC_TS_DTMF_BIT 10
`define ITC_TX_TABLE_BIT 15
`define ITC_TX_NUM_MSB 14
`define ITC_TX_NUM_LSB 11
`define ITC_TX_EN_BIT 7
`define ITC_TX_TWIST_BIT 6
`define ITC_TX_SINGLE_BIT 5
`define ITC_TX_DTMF_BIT 4

// ============================================================
// programming parameter indices and reset values
`define ITC_P_LEVEL 5'd0
`define ITC_P_SEQ0 5'd2
`define ITC_P_CUST1 5'd18
`define ITC_P_BW 5'd22
`define ITC_P_THR 5'd23
`define ITC_P_COUNT 24
`define ITC_RST_LEVEL 12'h400
`define ITC_RST_BW 12'h014
`define ITC_RST_THR 12'h040

// ============================================================
// tone limits and synthesis scaling
`define ITC_FREQ_MIN_HZ 12'd288
`define ITC_FREQ_MAX_HZ 12'd3000
`define ITC_TWIST_NUM 8'hCB
`define ITC_PHASE_PER_HZ 8'hAC

`endif

// File: rtl/itc_pkg.sv
/*
 * Types shared by the inband tone codec modules.
 * Assumes itc_defines.svh supplies the numeric constants.
 */
package itc_pkg;

	// ============================================================
	// decoder scan states, one-hot
	typedef enum logic [2:0] {
		ITC_IDLE = 3'b001,
		ITC_SCAN = 3'b010,
		ITC_DONE = 3'b100
	} itc_state_t;

	// inband mode field values
	typedef enum logic [2:0] {
		ITC_MODE_OFF = 3'h0,
		ITC_MODE_SEQ = 3'h1,
		ITC_MODE_CUST = 3'h2,
		ITC_MODE_BOTH = 3'h3
	} itc_mode_t;

	typedef logic [11:0] itc_freq_t;

endpackage : itc_pkg

// File: rtl/itc_tone_if.sv
/*
 * Tone settings carried from the codec core to the tone generator.
 * Assumes both ends run on the same system clock.
 */
interface itc_tone_if;
	logic enable;
	itc_pkg::itc_freq_t freq_lo;
	itc_pkg::itc_freq_t freq_hi;
	logic [11:0] amp_lo;
	logic [11:0] amp_hi;

	// core drives the settings
	modport ctrl (output enable, freq_lo, freq_hi, amp_lo, amp_hi);
	// generator consumes them
	modport gen (input enable, freq_lo, freq_hi, amp_lo, amp_hi);
endinterface : itc_tone_if

// File: rtl/itc_tone_gen.sv
/*
 * Two-component square tone synthesiser for inband and DTMF transmit.
 * Assumes settings are stable while enabled; a zero frequency mutes
 * its component.
 */
`include "itc_defines.svh"

module itc_tone_gen (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// settings from the core
	itc_tone_if.gen tif,
	// output sample
	output logic signed [15:0] sample
);

	logic [31:0] acc_lo_q, acc_lo_d;
	logic [31:0] acc_hi_q, acc_hi_d;
	logic signed [15:0] sample_q, sample_d;
	logic signed [13:0] part_lo, part_hi;

	// ============================================================
	// phase accumulators and mixer
	always_comb begin
		// widen before the product: inside a concatenation it would wrap
		acc_lo_d = acc_lo_q
			+ {12'h000, 20'(tif.freq_lo) * 20'(`ITC_PHASE_PER_HZ)};
		acc_hi_d = acc_hi_q
			+ {12'h000, 20'(tif.freq_hi) * 20'(`ITC_PHASE_PER_HZ)};
		part_lo = 14'sh0000;
		part_hi = 14'sh0000;
		if (tif.freq_lo != 12'h000) begin
			part_lo = acc_lo_q[31] ? -$signed({2'b00, tif.amp_lo})
				: $signed({2'b00, tif.amp_lo});
		end
		if (tif.freq_hi != 12'h000) begin
			part_hi = acc_hi_q[31] ? -$signed({2'b00, tif.amp_hi})
				: $signed({2'b00, tif.amp_hi});
		end
		sample_d = 16'sh0000;
		if (tif.enable) begin
			sample_d = 16'(part_lo + part_hi);
		end
		// restart phase while idle so each burst starts clean
		if (!tif.enable) begin
			acc_lo_d = 32'h00000000;
			acc_hi_d = 32'h00000000;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			acc_lo_q <= 32'h00000000;
			acc_hi_q <= 32'h00000000;
			sample_q <= 16'sh0000;
		end else begin
			acc_lo_q <= acc_lo_d;
			acc_hi_q <= acc_hi_d;
			sample_q <= sample_d;
		end
	end

	assign sample = sample_q;

endmodule : itc_tone_gen

// File: rtl/inband_tone_codec.sv
/*
 * Inband tone codec core: registers, tone table, decoder and transmit
 * tone selection. Assumes an upstream analyser delivers the dominant
 * receive frequency and magnitude as a strobed pair, and a DTMF
 * detector delivers detected key codes as a strobe.
 */
// Summary of operation
// - tones usable from 288 Hz to 3000 Hz for receive and transmit
// - reset loads default sequential set; host may overwrite entries
// - mode control bits 11 to 9 select inband mode
// - detection runs alongside audio or data reception
// - every valid tone state change raises an enabled interrupt
// - custom tones one to four come from their four parameters
// - scan table in order, report first match, set IRQ bit 13
// - detection bandwidth and threshold are programmable parameters
// - code bit 15 picks table, bits 14 to 11 pick tone
// - sequential tones 0 to 15 come from their sixteen parameters
// - received repeat tone reported plainly as tone 14
// - DTMF detection enabled by mode register, may run alongside inband
// - DTMF sets status bit 10, IRQ bit 12, overwrites tone
// - tx tone register picks tone; level parameter sets amplitude
// - DTMF codes map to the standard keypad tone pairs
// - twist bit lowers low DTMF component by 2 dB
// - single-tone bit sends only the designated DTMF component
`include "itc_defines.svh"

module inband_tone_codec #(
	parameter int N_PARAMS = `ITC_P_COUNT
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	// receive analyser
	input wire logic [11:0] RX_FREQ,
	input wire logic [11:0] RX_MAG,
	input wire logic RX_STROBE,
	// DTMF detector
	input wire logic DTMF_DET,
	input wire logic [3:0] DTMF_CODE,
	// transmit audio and interrupt request
	output logic signed [15:0] TX_SAMPLE,
	output logic IRQ_REQ
);

	// ============================================================
	// functions
	function automatic logic in_range(input logic [11:0] f);
		in_range = (f >= `ITC_FREQ_MIN_HZ) && (f <= `ITC_FREQ_MAX_HZ);
	endfunction : in_range

	function automatic logic [11:0] dtmf_low(input logic [3:0] c);
		case (c)
			4'h1, 4'h2, 4'h3, 4'hD: dtmf_low = 12'd697;
			4'h4, 4'h5, 4'h6, 4'hE: dtmf_low = 12'd770;
			4'h7, 4'h8, 4'h9, 4'hF: dtmf_low = 12'd852;
			default: dtmf_low = 12'd941;
		endcase
	endfunction : dtmf_low

	function automatic logic [11:0] dtmf_high(input logic [3:0] c);
		case (c)
			4'h1, 4'h4, 4'h7, 4'hB: dtmf_high = 12'd1209;
			4'h2, 4'h5, 4'h8, 4'hA: dtmf_high = 12'd1336;
			4'h3, 4'h6, 4'h9, 4'hC: dtmf_high = 12'd1477;
			default: dtmf_high = 12'd1633;
		endcase
	endfunction : dtmf_high

	// default table entry loaded at reset
	function automatic logic [11:0] param_default(input int i);
		case (i)
			0: param_default = `ITC_RST_LEVEL;
			2: param_default = 12'd1981;
			3: param_default = 12'd1124;
			4: param_default = 12'd1197;
			5: param_default = 12'd1275;
			6: param_default = 12'd1358;
			7: param_default = 12'd1446;
			8: param_default = 12'd1540;
			9: param_default = 12'd1640;
			10: param_default = 12'd1747;
			11: param_default = 12'd1860;
			12: param_default = 12'd1055;
			13: param_default = 12'd930;
			14: param_default = 12'd2247;
			15: param_default = 12'd991;
			16: param_default = 12'd2110;
			17: param_default = 12'd2400;
			22: param_default = `ITC_RST_BW;
			23: param_default = `ITC_RST_THR;
			default: param_default = 12'h000;
		endcase
	endfunction : param_default

	// ============================================================
	// state
	logic [15:0] mode_q, mode_d;
	logic [15:0] txtone_q, txtone_d;
	logic [15:0] irqst_q, irqst_d;
	logic [15:0] irqen_q, irqen_d;
	logic [15:0] tonest_q, tonest_d;
	logic [4:0] psel_q, psel_d;
	logic [15:0] rdata_q, rdata_d;
	logic [11:0] ptab_q [N_PARAMS];
	logic [11:0] ptab_d [N_PARAMS];
	itc_pkg::itc_state_t st_q, st_d;
	logic [4:0] idx_q, idx_d;
	logic [11:0] fr_q, fr_d;
	logic [11:0] mag_q, mag_d;
	logic [4:0] res_q, res_d;
	logic [4:0] prev_q, prev_d;
	itc_pkg::itc_mode_t imode;
	logic [4:0] pidx;
	logic [11:0] entry, diff;
	logic hit, last;
	logic set_inband, set_dtmf;

	itc_tone_if tif ();

	// inband mode from bits 11 to 9
	assign imode = itc_pkg::itc_mode_t'(
		mode_q[`ITC_MODE_MSB:`ITC_MODE_LSB]);

	// ============================================================
	// decoder scan: sequential entries 0..15 first, then custom 1..4
	always_comb begin
		pidx = (idx_q < 5'd16) ? (idx_q + `ITC_P_SEQ0)
			: (idx_q + 5'd2);
		entry = ptab_q[pidx];
		diff = (fr_q > entry) ? (fr_q - entry) : (entry - fr_q);
		hit = in_range(entry) && (diff <= ptab_q[`ITC_P_BW]);
		// a mode change mid-scan must still stop inside the table
		last = ((imode == itc_pkg::ITC_MODE_SEQ) && (idx_q == 5'd15))
			|| (idx_q >= 5'd19);
	end

	always_comb begin
		st_d = st_q;
		idx_d = idx_q;
		fr_d = fr_q;
		mag_d = mag_q;
		res_d = res_q;
		prev_d = prev_q;
		set_inband = 1'b0;
		case (st_q)
			itc_pkg::ITC_IDLE: begin
				// runs independently of the audio and data paths
				if (RX_STROBE && (imode == itc_pkg::ITC_MODE_SEQ
					|| imode == itc_pkg::ITC_MODE_CUST
					|| imode == itc_pkg::ITC_MODE_BOTH)) begin
					st_d = itc_pkg::ITC_SCAN;
					fr_d = RX_FREQ;
					mag_d = RX_MAG;
					idx_d = (imode == itc_pkg::ITC_MODE_CUST) ? 5'd16 : 5'd0;
				end
			end
			itc_pkg::ITC_SCAN: begin
				if (mag_q < ptab_q[`ITC_P_THR]) begin
					res_d = 5'h00; // below threshold: no tone
					st_d = itc_pkg::ITC_DONE;
				end else if (hit) begin
					// first match wins; tone 14 is reported as is
					res_d = (idx_q < 5'd16) ? {1'b1, idx_q[3:0]}
						: {1'b0, 4'(idx_q - 5'd15)};
					st_d = itc_pkg::ITC_DONE;
				end else if (last) begin
					res_d = 5'h0F; // signal present, unrecognised
					st_d = itc_pkg::ITC_DONE;
				end else begin
					idx_d = idx_q + 5'd1;
				end
			end
			itc_pkg::ITC_DONE: begin
				st_d = itc_pkg::ITC_IDLE;
				// on, off or a different tone
				if (res_q != prev_q) begin
					set_inband = 1'b1;
					prev_d = res_q;
				end
			end
			default: st_d = itc_pkg::ITC_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			st_q <= itc_pkg::ITC_IDLE;
			idx_q <= 5'h00;
			fr_q <= 12'h000;
			mag_q <= 12'h000;
			res_q <= 5'h00;
			prev_q <= 5'h00;
		end else begin
			st_q <= st_d;
			idx_q <= idx_d;
			fr_q <= fr_d;
			mag_q <= mag_d;
			res_q <= res_d;
			prev_q <= prev_d;
		end
	end

	assign set_dtmf = DTMF_DET && mode_q[`ITC_MODE_DTMF_BIT];

	// ============================================================
	// register file, parameter table and status flags
	always_comb begin
		mode_d = mode_q;
		txtone_d = txtone_q;
		irqen_d = irqen_q;
		psel_d = psel_q;
		tonest_d = tonest_q;
		irqst_d = irqst_q;
		rdata_d = 16'h0000;
		for (int i = 0; i < N_PARAMS; i++) begin
			ptab_d[i] = ptab_q[i];
		end
		if (WR) begin
			case (ADDR)
				`ITC_ADDR_MODE: mode_d = WDATA;
				`ITC_ADDR_TXTONE: txtone_d = WDATA;
				`ITC_ADDR_IRQEN: irqen_d = WDATA;
				`ITC_ADDR_PSEL: psel_d = WDATA[4:0];
				`ITC_ADDR_PROG: begin
					// host overwrites any entry, index steps on
					if (int'(psel_q) < N_PARAMS) begin
						ptab_d[psel_q] = WDATA[11:0];
					end
					psel_d = psel_q + 5'd1;
				end
				default: ;
			endcase
		end
		if (RD) begin
			case (ADDR)
				`ITC_ADDR_MODE: rdata_d = mode_q;
				`ITC_ADDR_TXTONE: rdata_d = txtone_q;
				`ITC_ADDR_IRQST: begin
					rdata_d = irqst_q;
					irqst_d = 16'h0000; // read clears
				end
				`ITC_ADDR_IRQEN: rdata_d = irqen_q;
				`ITC_ADDR_TONEST: rdata_d = tonest_q;
				`ITC_ADDR_PSEL: rdata_d = {11'h000, psel_q};
				`ITC_ADDR_PROG: rdata_d = (int'(psel_q) < N_PARAMS)
					? {4'h0, ptab_q[psel_q]} : 16'h0000;
				default: rdata_d = 16'h0000;
			endcase
		end
		// new tone state after the read-clear so a set is never lost
		if (set_inband) begin
			tonest_d = {res_q, 11'h000};
			irqst_d[`ITC_IRQ_INBAND_BIT] = 1'b1;
		end
		// DTMF replaces whatever tone value was held
		if (set_dtmf) begin
			tonest_d = {5'h00, 1'b1, 6'h00, DTMF_CODE};
			irqst_d[`ITC_IRQ_DTMF_BIT] = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			mode_q <= 16'h0000;
			txtone_q <= 16'h0000;
			irqst_q <= 16'h0000;
			irqen_q <= 16'h0000;
			tonest_q <= 16'h0000;
			psel_q <= 5'h00;
			rdata_q <= 16'h0000;
			for (int i = 0; i < N_PARAMS; i++) begin
				ptab_q[i] <= param_default(i);
			end
		end else begin
			mode_q <= mode_d;
			txtone_q <= txtone_d;
			irqst_q <= irqst_d;
			irqen_q <= irqen_d;
			tonest_q <= tonest_d;
			psel_q <= psel_d;
			rdata_q <= rdata_d;
			for (int i = 0; i < N_PARAMS; i++) begin
				ptab_q[i] <= ptab_d[i];
			end
		end
	end

	// ============================================================
	// transmit tone selection
	logic [3:0] tnum;
	logic [11:0] lvl, lvl_tw, f_one;
	logic [19:0] tw_prod;

	always_comb begin
		tnum = txtone_q[`ITC_TX_NUM_MSB:`ITC_TX_NUM_LSB];
		lvl = ptab_q[`ITC_P_LEVEL];
		tw_prod = lvl * `ITC_TWIST_NUM;
		lvl_tw = tw_prod[19:8]; // about -2 dB
		tif.enable = txtone_q[`ITC_TX_EN_BIT];
		tif.freq_lo = 12'h000;
		tif.freq_hi = 12'h000;
		tif.amp_lo = lvl;
		tif.amp_hi = lvl;
		f_one = 12'h000;
		if (txtone_q[`ITC_TX_DTMF_BIT]) begin
			tif.freq_lo = dtmf_low(txtone_q[3:0]);
			tif.freq_hi = dtmf_high(txtone_q[3:0]);
			if (txtone_q[`ITC_TX_TWIST_BIT]) begin
				tif.amp_lo = lvl_tw;
			end
			// keep only the designated component
			if (txtone_q[`ITC_TX_SINGLE_BIT]) begin
				if (txtone_q[3:0] >= 4'h8) begin
					tif.freq_lo = 12'h000;
				end else begin
					tif.freq_hi = 12'h000;
				end
			end
		end else begin
			// custom codes other than 1..4 give silence
			if (txtone_q[`ITC_TX_TABLE_BIT]) begin
				f_one = ptab_q[5'(tnum) + `ITC_P_SEQ0];
			end else if (tnum >= 4'h1 && tnum <= 4'h4) begin
				f_one = ptab_q[5'(tnum) + 5'd17];
			end else begin
				f_one = 12'h000;
			end
			// entries outside the usable band are muted
			tif.freq_hi = in_range(f_one) ? f_one : 12'h000;
		end
	end

	itc_tone_gen u_gen (
		.clk(SYS_CLK),
		.rst(RESET),
		.tif(tif.gen),
		.sample(TX_SAMPLE)
	);

	// ============================================================
	// outputs
	assign RDATA = rdata_q;
	assign IRQ_REQ = |(irqst_q & irqen_q);

endmodule : inband_tone_codec

// File: verif/itc_properties.sv
/* Port checker for the inband tone codec.
   Assumes it is bound onto inband_tone_codec; one clock, sync reset. */
`include "itc_defines.svh"
module itc_properties #(
	parameter int N_PARAMS = 24
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	// receive side
	input wire logic [11:0] RX_FREQ,
	input wire logic [11:0] RX_MAG,
	input wire logic RX_STROBE,
	input wire logic DTMF_DET,
	input wire logic [3:0] DTMF_CODE,
	// outputs
	input wire logic signed [15:0] TX_SAMPLE,
	input wire logic IRQ_REQ
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mode_q, mode_d, ien_q, ien_d, tx_q, tx_d;
	logic [2:0] age_q, age_d;
	logic [4:0] since_q, since_d;
	logic quiet;
	// ============================================================
	// shadow of host writes, so properties see mode and enables
	always_comb begin
		mode_d = (WR && ADDR == `ITC_ADDR_MODE) ? WDATA : mode_q;
		ien_d = (WR && ADDR == `ITC_ADDR_IRQEN) ? WDATA : ien_q;
		tx_d = (WR && ADDR == `ITC_ADDR_TXTONE) ? WDATA : tx_q;
		age_d = WR ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
		since_d = (RX_STROBE || DTMF_DET || WR) ? 5'h00 :
			(since_q == 5'h1F ? since_q : since_q + 5'h01);
	end
	always_ff @(posedge SYS_CLK) begin
		mode_q <= RESET ? 16'h0000 : mode_d;
		ien_q <= RESET ? 16'h0000 : ien_d;
		tx_q <= RESET ? 16'h0000 : tx_d;
		age_q <= RESET ? 3'h0 : age_d;
		since_q <= RESET ? 5'h1F : since_d;
	end
	// no enable, or a custom code 0 or 5 to 14, which names no tone
	assign quiet = !tx_q[7] || (!tx_q[15] && !tx_q[4] &&
		(tx_q[14:11] == 4'h0 || (tx_q[14:11] > 4'h4 && tx_q[14:11] < 4'hF)));
	// ============================================================
	// properties
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	sequence s_clr_read;
		RD && ADDR == `ITC_ADDR_IRQST && mode_q[11:8] == 4'h0;
	endsequence
	sequence s_no_write;
		!WR [*2];
	endsequence
	irq_clear_a: assert property (
		s_clr_read ##0 s_no_write |-> !IRQ_REQ)
		else $error("interrupt stays after status read");
	irq_masked_a: assert property (
		$past(ien_q[13:12]) == 2'h0 && ien_q[13:12] == 2'h0
		|-> !IRQ_REQ)
		else $error("masked interrupt raised");
	dtmf_irq_a: assert property (
		DTMF_DET && mode_q[8] && ien_q[12] |-> ##[1:2] IRQ_REQ)
		else $error("keypad detect gave no interrupt");
	dtmf_off_a: assert property (
		DTMF_DET && mode_q[11:8] == 4'h0 && !IRQ_REQ |=> !IRQ_REQ)
		else $error("keypad detect acted while disabled");
	mode_back_a: assert property (
		RD && ADDR == `ITC_ADDR_MODE |=> RDATA[11:8] == mode_q[11:8])
		else $error("mode field reads back wrong");
	param_hi_a: assert property (
		RD && ADDR == `ITC_ADDR_PROG |=> RDATA[15:12] == 4'h0)
		else $error("parameter upper bits not zero");
	tx_quiet_a: assert property (
		age_q == 3'h7 && quiet |-> TX_SAMPLE == 16'h0000)
		else $error("tone output not silent");
	irq_cause_a: assert property (
		$rose(IRQ_REQ) |-> since_q < 5'h19)
		else $error("interrupt without a recent event");
endmodule : itc_properties

bind inband_tone_codec itc_properties #(.N_PARAMS(N_PARAMS)) u_props (
	.SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .RX_FREQ(RX_FREQ), .RX_MAG(RX_MAG),
	.RX_STROBE(RX_STROBE), .DTMF_DET(DTMF_DET), .DTMF_CODE(DTMF_CODE),
	.TX_SAMPLE(TX_SAMPLE), .IRQ_REQ(IRQ_REQ));

// File: verif/itc_src_model.sv
/* Model of the receive analyser and keypad detector feeding the codec.
   Assumes the caller spaces measurements by the scan time. */
module itc_src_model (
	// clock
	input wire logic clk,
	// analyser measurement
	output logic [11:0] rx_freq,
	output logic [11:0] rx_mag,
	output logic rx_strobe,
	// keypad detector
	output logic dtmf_det,
	output logic [3:0] dtmf_code
);
	timeunit 1ns;
	timeprecision 1ns;
	// ============================================================
	// idle levels at time zero
	initial begin
		rx_freq = 12'h000;
		rx_mag = 12'h000;
		rx_strobe = 1'b0;
		dtmf_det = 1'b0;
		dtmf_code = 4'h0;
	end
	// one pulse; the bus then shows junk so stale values cannot pass
	task automatic tone(input logic [11:0] f, input logic [11:0] m);
		@(posedge clk);
		rx_freq <= f;
		rx_mag <= m;
		rx_strobe <= 1'b1;
		@(posedge clk);
		rx_freq <= ~f;
		rx_mag <= ~m;
		rx_strobe <= 1'b0;
	endtask : tone
	task automatic key(input logic [3:0] c);
		@(posedge clk);
		dtmf_code <= c;
		dtmf_det <= 1'b1;
		@(posedge clk);
		dtmf_code <= ~c;
		dtmf_det <= 1'b0;
	endtask : key
endmodule : itc_src_model

// File: verif/testbench.sv
/* Self-checking bench for the inband tone codec.
   Assumes the design and its checker are compiled first. */
`include "itc_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	n_errors++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic SYS_CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, rd_q = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [15:0] WDATA = 16'h0000, RDATA, prev = 16'h0000, e, m;
	logic [11:0] RX_FREQ, RX_MAG, lvl;
	logic RX_STROBE, DTMF_DET, IRQ_REQ;
	logic [3:0] DTMF_CODE;
	logic signed [15:0] TX_SAMPLE;
	logic [15:0] eq[$], mq[$];
	logic [11:0] seq_def[16] = '{12'd1981, 12'd1124, 12'd1197, 12'd1275,
		12'd1358, 12'd1446, 12'd1540, 12'd1640, 12'd1747, 12'd1860,
		12'd1055, 12'd930, 12'd2247, 12'd991, 12'd2110, 12'd2400};
	int n_errors = 0, checks_done = 0, i, k;
	// ============================================================
	// clock, design and analyser model
	initial forever #20 SYS_CLK = ~SYS_CLK;
	inband_tone_codec DUT (.SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RX_FREQ(RX_FREQ),
		.RX_MAG(RX_MAG), .RX_STROBE(RX_STROBE), .DTMF_DET(DTMF_DET),
		.DTMF_CODE(DTMF_CODE), .TX_SAMPLE(TX_SAMPLE), .IRQ_REQ(IRQ_REQ));
	itc_src_model src (.clk(SYS_CLK), .rx_freq(RX_FREQ), .rx_mag(RX_MAG),
		.rx_strobe(RX_STROBE), .dtmf_det(DTMF_DET), .dtmf_code(DTMF_CODE));
	// read data stands one cycle after the strobe; check it mid-cycle
	always @(posedge SYS_CLK) rd_q <= RD;
	always @(negedge SYS_CLK) begin
		if (rd_q) begin
			e = eq.pop_front();
			m = mq.pop_front();
			`CHK(RDATA & m, e)
		end
	end
	// ============================================================
	// bus and scenario tasks
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] x, msk);
		eq.push_back(x & msk);
		mq.push_back(msk);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
	endtask : rd
	task automatic par(input int idx, input logic [11:0] v);
		wr(`ITC_ADDR_PSEL, 16'(idx));
		wr(`ITC_ADDR_PROG, {4'h0, v});
	endtask : par
	task automatic prd(input int idx, input logic [15:0] x);
		wr(`ITC_ADDR_PSEL, 16'(idx));
		rd(`ITC_ADDR_PROG, x, 16'hFFFF);
	endtask : prd
	// interrupt only when the reported code really changes
	task automatic rx(input logic [11:0] f, mg, input logic [15:0] c);
		logic chg;
		chg = (c != prev);
		prev = c;
		src.tone(f, mg);
		repeat (30) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
		`CHK(IRQ_REQ, chg)
		rd(`ITC_ADDR_TONEST, c, 16'hF800);
		rd(`ITC_ADDR_IRQST, {2'b00, chg, 13'h0000}, 16'h3000);
	endtask : rx
	// square tones: each sample is a sum of +-a and +-b
	task automatic tx(input logic [15:0] c3, input logic signed [15:0] a, b);
		wr(`ITC_ADDR_TXTONE, c3);
		repeat (4) @(posedge SYS_CLK);
		for (int j = 0; j < 64; j++) begin
			@(negedge SYS_CLK);
			`CHK(TX_SAMPLE == a + b || TX_SAMPLE == -a - b ||
				TX_SAMPLE == a - b || TX_SAMPLE == b - a, 1'b1)
		end
	endtask : tx
	// cut a hang short
	initial begin
		repeat (60000) @(posedge SYS_CLK);
		n_errors++;
		$display("ERROR %0t: run timed out", $time);
		wrap_up();
	end
	// ============================================================
	// main sequence
	initial begin
		void'($urandom(32'h79A19EB6));
		repeat (4) @(posedge SYS_CLK);
		RESET <= 1'b0;
		for (i = 0; i < 16; i++) prd(2 + i, {4'h0, seq_def[i]});
		prd(0, 16'h0400);
		prd(22, 16'h0014);
		prd(23, 16'h0040);
		rd(8'h00, 16'h0000, 16'hFFFF);
		$display("defaults done");
		wr(`ITC_ADDR_IRQEN, 16'h3000);
		wr(`ITC_ADDR_MODE, 16'h0200);
		rd(`ITC_ADDR_MODE, 16'h0200, 16'h0F00);
		par(5, 12'd1124);
		rx(12'd1124, 12'h100, 16'h8800);
		for (i = 0; i < 4; i++) begin
			k = $urandom % 16;
			if (k == 3) k = 0;
			rx(seq_def[k] + 12'($urandom % 5) - 12'd2, 12'h100,
				{1'b1, 4'(k), 11'h000});
		end
		rx(12'd2110, 12'h100, 16'hF000);
		rx(12'd2110, 12'h010, 16'h0000);
		wr(`ITC_ADDR_MODE, 16'h0400);
		par(18, 12'd500);
		par(19, 12'd250);
		rx(12'd500, 12'h100, 16'h0800);
		rx(12'd250, 12'h100, 16'h7800);
		rx(12'd700, 12'h100, 16'h7800);
		// both tables: sequential scanned first, then the custom tones
		wr(`ITC_ADDR_MODE, 16'h0600);
		rx(12'd500, 12'h100, 16'h0800);
		$display("inband receive done");
		wr(`ITC_ADDR_MODE, 16'h0100);
		for (i = 0; i < 16; i++) begin
			src.key(4'(i));
			rd(`ITC_ADDR_TONEST, 16'h0400 | 16'(i), 16'h040F);
			rd(`ITC_ADDR_IRQST, 16'h1000, 16'h3000);
		end
		wr(`ITC_ADDR_MODE, 16'h0000);
		src.key(4'h5);
		rd(`ITC_ADDR_IRQST, 16'h0000, 16'h3000);
		$display("keypad receive done");
		lvl = 12'h100 + 12'($urandom % 1536);
		par(0, lvl);
		tx(16'h8880, 16'(lvl), 16'h0000);
		tx(16'h00B5, 16'(lvl), 16'h0000);
		tx(16'h00D5, 16'(lvl), 16'((lvl * 203) / 256));
		tx(16'h3880, 16'h0000, 16'h0000);
		tx(16'h0800, 16'h0000, 16'h0000);
		$display("transmit done");
		wrap_up();
	end
endmodule : testbench
